// file: hw/sfp_map.svh
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH
// opcodes
`define SFP_OP_WRSTAT 8'h01
`define SFP_OP_WRITE_ENABLE_CMD 8'h06
`define SFP_OP_WRDIS 8'h04
`define SFP_OP_RDSTAT 8'h05
`define SFP_OP_SECT 8'h20
`define SFP_OP_BLOCK 8'hd8
`define SFP_OP_CHIP1 8'h60
`define SFP_OP_CHIP2 8'hc7
`define SFP_OP_PROG 8'h02
`define SFP_OP_DREAD 8'h3b
// status bit positions
`define SFP_ST_BUSY 0
`define SFP_ST_WEL 1
`define SFP_ST_BP_LO 2
`define SFP_ST_BP_HI 4
`define SFP_ST_LOCK 7
// reset values
`define SFP_BP_RST 3'h7
`define SFP_LOCK_RST 1'h0
// bus cycle length in bits
`define SFP_BITS 4'h8
`endif

// file: hw/sfp_pkg.sv
package sfp_pkg;
   typedef enum logic [2:0] {
      SFP_OPC = 3'b000,
      SFP_ADR = 3'b001,
      SFP_DAT = 3'b011,
      SFP_DUM = 3'b010,
      SFP_OUT = 3'b110,
      SFP_IGN = 3'b111
   } sfp_phase_t;
   typedef struct packed {
      logic [2:0] bp;
      logic lock;
      logic write_enable_latch;
   } sfp_status_t;
   typedef struct packed {
      logic valid;
      logic [1:0] kind;
      logic [23:0] addr;
   } sfp_erase_t;
endpackage : sfp_pkg

// file: hw/sfp_cmd.sv
`include "sfp_map.svh"
module sfp_cmd
   import sfp_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // serial pins
   input wire logic i_cs_n,
   input wire logic i_sck,
   input wire logic i_si,
   input wire logic i_hold_n,
   input wire logic i_wp_n,
   output logic o_so,
   output logic o_so_oe,
   output logic o_io1,
   output logic o_io1_oe,
   // array side
   input wire logic i_busy,
   input wire logic [7:0] i_rd_data,
   output logic o_rd_req,
   output logic [23:0] o_addr,
   output logic o_erase_go,
   output logic [1:0] o_erase_kind,
   output logic o_prog_go,
   output logic [7:0] o_prog_data,
   output logic o_refused,
   output logic [7:0] o_status
);
   ////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [4:0] sync1, sync2, pins_d;
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sync1 <= 5'h1f;
         sync2 <= 5'h1f;
         pins_d <= 5'h1f;
      end else begin
         sync1 <= {i_cs_n, i_sck, i_si, i_hold_n, i_wp_n};
         sync2 <= sync1;
         pins_d <= sync2;
      end
   end
   logic cs_n, sck, si, hold_n, wp_n, sck_rise, sck_fall, cs_rise;
   assign {cs_n, sck, si, hold_n, wp_n} = sync2;
   assign sck_rise = sck & ~pins_d[3];
   assign sck_fall = ~sck & pins_d[3];
   assign cs_rise = cs_n & ~pins_d[4];

   ////////////////////////////////////////////////////////////////////
   // pause control
   logic paused, next_paused;
   always_comb begin
      next_paused = paused;
      if (cs_n) next_paused = 1'b0;
      else if (!sck && !hold_n) next_paused = 1'b1;
      else if (!sck && hold_n) next_paused = 1'b0;
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) paused <= 1'b0;
      else paused <= next_paused;
   end
   logic live_rise, live_fall;
   assign live_rise = sck_rise & ~cs_n & ~paused;
   assign live_fall = sck_fall & ~cs_n & ~paused;

   ////////////////////////////////////////////////////////////////////
   // command engine
   sfp_phase_t phase, next_phase;
   logic [7:0] opc, next_opc, shf, next_shf, oshf, next_oshf;
   logic [3:0] bcnt, next_bcnt;
   logic [1:0] acnt, next_acnt;
   logic [23:0] addr, next_addr;
   logic [2:0] bp, next_bp;
   logic lock, next_lock, write_enable_latch, next_wel, drive, next_drive, dual, next_dual;
   logic erase_go, next_erase_go, prog_go, next_prog_go, rd_req, next_rd_req;
   logic refused, next_refused, stat_ok, got_prog, next_got_prog;
   logic [1:0] ekind, next_ekind;
   logic [7:0] pdata, next_pdata, sbyte, stat;
   logic [23:0] prot_base;
   logic hit_prot;
   assign stat_ok = wp_n | ~lock;
   // upper fraction: level n protects top 2^(n-1) blocks of 64
   always_comb begin
      case (bp)
         3'h0: prot_base = 24'h400000;
         3'h1: prot_base = 24'h3f0000;
         3'h2: prot_base = 24'h3e0000;
         3'h3: prot_base = 24'h3c0000;
         3'h4: prot_base = 24'h380000;
         3'h5: prot_base = 24'h300000;
         3'h6: prot_base = 24'h200000;
         default: prot_base = 24'h000000;
      endcase
   end
   assign hit_prot = (addr[21:0] >= prot_base[21:0]) & (bp != 3'h0);
   assign sbyte = {shf[6:0], si};
   always_comb begin
      stat = 8'h00;
      stat[`SFP_ST_BUSY] = i_busy;
      stat[`SFP_ST_WEL] = write_enable_latch;
      stat[`SFP_ST_BP_HI:`SFP_ST_BP_LO] = bp;
      stat[`SFP_ST_LOCK] = lock;
   end
   always_comb begin
      next_phase = phase;
      next_opc = opc;
      next_shf = shf;
      next_oshf = oshf;
      next_bcnt = bcnt;
      next_acnt = acnt;
      next_addr = addr;
      next_bp = bp;
      next_lock = lock;
      next_wel = write_enable_latch;
      next_drive = drive;
      next_dual = dual;
      next_erase_go = 1'b0;
      next_prog_go = 1'b0;
      next_rd_req = 1'b0;
      next_refused = 1'b0;
      next_ekind = ekind;
      next_pdata = pdata;
      next_got_prog = got_prog;
      // program address steps only after the byte and its address left together
      if (prog_go) next_addr = {addr[23:8], addr[7:0] + 8'h1};
      if (cs_rise) begin
         // completion checks only on a whole-byte boundary
         if (bcnt == 4'h0 && !paused) begin
            if (phase == SFP_ADR || phase == SFP_IGN) begin
               if (opc == `SFP_OP_SECT || opc == `SFP_OP_BLOCK) begin
                  if (acnt == 2'h3 && write_enable_latch && !hit_prot && !i_busy) begin
                     next_erase_go = 1'b1;
                     next_ekind = (opc == `SFP_OP_SECT) ? 2'h0 : 2'h1;
                  end else next_refused = 1'b1;
                  next_wel = 1'b0;
               end
            end
            if (phase == SFP_OPC && (opc == `SFP_OP_CHIP1 || opc == `SFP_OP_CHIP2)) begin
               if (write_enable_latch && bp == 3'h0 && !i_busy) begin
                  next_erase_go = 1'b1;
                  next_ekind = 2'h2;
               end else next_refused = 1'b1;
               next_wel = 1'b0;
            end
            if (phase == SFP_OPC && opc == `SFP_OP_WRITE_ENABLE_CMD) next_wel = 1'b1;
            if (phase == SFP_OPC && opc == `SFP_OP_WRDIS) next_wel = 1'b0;
            if (got_prog) next_wel = 1'b0;
         end
         next_phase = SFP_OPC;
         next_bcnt = 4'h0;
         next_acnt = 2'h0;
         next_drive = 1'b0;
         next_dual = 1'b0;
         next_got_prog = 1'b0;
      end else if (cs_n) begin
         next_phase = SFP_OPC;
         next_bcnt = 4'h0;
         next_acnt = 2'h0;
         next_drive = 1'b0;
         next_dual = 1'b0;
      end else if (live_fall && drive && bcnt != 4'h0) begin
         next_oshf = dual ? {oshf[5:0], 2'h0} : {oshf[6:0], 1'b0};
      end else if (live_rise) begin
         next_shf = sbyte;
         next_bcnt = (bcnt == `SFP_BITS - 4'h1) ? 4'h0 : bcnt + 4'h1;
         if (phase == SFP_OUT && dual) next_bcnt = (bcnt == 4'h3) ? 4'h0 : bcnt + 4'h1;
         if (phase == SFP_OUT && next_bcnt == 4'h0) begin
            next_addr = addr + 24'h1;
            next_rd_req = ~dual | 1'b1;
            next_oshf = dual ? i_rd_data : stat;
            if (!dual) next_oshf = (opc == `SFP_OP_RDSTAT) ? stat : i_rd_data;
         end
         if (bcnt == `SFP_BITS - 4'h1 && phase != SFP_OUT) begin
            case (phase)
               SFP_OPC: begin
                  next_opc = sbyte;
                  case (sbyte)
                     `SFP_OP_SECT, `SFP_OP_BLOCK, `SFP_OP_PROG, `SFP_OP_DREAD:
                        next_phase = SFP_ADR;
                     `SFP_OP_WRSTAT: next_phase = SFP_DAT;
                     `SFP_OP_RDSTAT: begin
                        next_phase = SFP_OUT;
                        next_drive = 1'b1;
                        next_oshf = stat;
                     end
                     default: next_phase = SFP_OPC;
                  endcase
               end
               SFP_ADR: begin
                  next_addr = {addr[15:0], sbyte};
                  next_acnt = acnt + 2'h1;
                  if (acnt == 2'h2) begin
                     if (opc == `SFP_OP_DREAD) next_phase = SFP_DUM;
                     else if (opc == `SFP_OP_PROG) next_phase = SFP_DAT;
                     else next_phase = SFP_IGN;
                  end
               end
               SFP_DUM: begin
                  next_phase = SFP_OUT;
                  next_drive = 1'b1;
                  next_dual = 1'b1;
                  next_rd_req = 1'b1;
                  next_oshf = i_rd_data;
                  next_addr = addr + 24'h1;
               end
               SFP_DAT: begin
                  if (opc == `SFP_OP_WRSTAT) begin
                     if (write_enable_latch && stat_ok) begin
                        next_bp = sbyte[`SFP_ST_BP_HI:`SFP_ST_BP_LO];
                        next_lock = sbyte[`SFP_ST_LOCK];
                     end else next_refused = 1'b1;
                     next_wel = 1'b0;
                     next_phase = SFP_IGN;
                  end else begin
                     if (write_enable_latch && !hit_prot && !i_busy) begin
                        next_prog_go = 1'b1;
                        next_pdata = sbyte;
                     end else next_refused = 1'b1;
                     next_got_prog = 1'b1;
                  end
               end
               default: next_phase = SFP_IGN;
            endcase
         end
      end
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         phase <= SFP_OPC;
         opc <= 8'h00;
         shf <= 8'h00;
         oshf <= 8'h00;
         bcnt <= 4'h0;
         acnt <= 2'h0;
         addr <= 24'h000000;
         bp <= `SFP_BP_RST;
         lock <= `SFP_LOCK_RST;
         write_enable_latch <= 1'b0;
         drive <= 1'b0;
         dual <= 1'b0;
         erase_go <= 1'b0;
         prog_go <= 1'b0;
         rd_req <= 1'b0;
         refused <= 1'b0;
         ekind <= 2'h0;
         pdata <= 8'h00;
         got_prog <= 1'b0;
      end else begin
         phase <= next_phase;
         opc <= next_opc;
         shf <= next_shf;
         oshf <= next_oshf;
         bcnt <= next_bcnt;
         acnt <= next_acnt;
         addr <= next_addr;
         bp <= next_bp;
         lock <= next_lock;
         write_enable_latch <= next_wel;
         drive <= next_drive;
         dual <= next_dual;
         erase_go <= next_erase_go;
         prog_go <= next_prog_go;
         rd_req <= next_rd_req;
         refused <= next_refused;
         ekind <= next_ekind;
         pdata <= next_pdata;
         got_prog <= next_got_prog;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_so <= 1'b0;
         o_so_oe <= 1'b0;
         o_io1 <= 1'b0;
         o_io1_oe <= 1'b0;
         o_rd_req <= 1'b0;
         o_addr <= 24'h000000;
         o_erase_go <= 1'b0;
         o_erase_kind <= 2'h0;
         o_prog_go <= 1'b0;
         o_prog_data <= 8'h00;
         o_refused <= 1'b0;
         o_status <= 8'h1c;
      end else begin
         o_so <= oshf[7];
         o_so_oe <= drive & ~paused & ~cs_n;
         o_io1 <= oshf[6];
         o_io1_oe <= drive & dual & ~paused & ~cs_n;
         o_rd_req <= rd_req;
         o_addr <= addr;
         o_erase_go <= erase_go;
         o_erase_kind <= ekind;
         o_prog_go <= prog_go;
         o_prog_data <= pdata;
         o_refused <= refused;
         o_status <= stat;
      end
   end
endmodule : sfp_cmd

// file: sim/sfp_cmd_props.sv
`include "sfp_map.svh"
module sfp_cmd_props (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // pins
   input wire logic i_cs_n,
   input wire logic i_hold_n,
   input wire logic i_wp_n,
   // outputs watched
   input wire logic o_so_oe,
   input wire logic o_io1_oe,
   input wire logic o_erase_go,
   input wire logic [1:0] o_erase_kind,
   input wire logic [23:0] o_addr,
   input wire logic o_refused,
   input wire logic [7:0] o_status
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   logic [3:0] wp_lo;
   logic [3:0] next_wp_lo;
   logic [3:0] hold_lo;
   logic [3:0] next_hold_lo;
   // upper area guarded by the protect size field
   function automatic logic prot(input logic [2:0] bp, input logic [23:0] a);
      return bp != 3'h0 && {1'b0, a[21:16]} >= 7'h40 - (7'h1 << (bp - 3'h1));
   endfunction : prot
   // saturating counts of write-protect low and of pause while selected
   always_comb begin
      next_wp_lo = (i_wp_n || wp_lo == 4'hf) ? {4{~i_wp_n}} : wp_lo + 4'h1;
      next_hold_lo = (i_hold_n || i_cs_n || hold_lo == 4'hf) ?
         {4{~(i_hold_n | i_cs_n)}} : hold_lo + 4'h1;
   end
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wp_lo <= 4'h0;
         hold_lo <= 4'h0;
      end else begin
         wp_lo <= next_wp_lo;
         hold_lo <= next_hold_lo;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   AST_RST_VAL: assert property ($fell(i_rst) |-> o_status == 8'h1c)
      else $error("status after reset wrong");
   AST_RSVD: assert property (o_status[6:5] == 2'h0)
      else $error("reserved status bits set");
   AST_CHIP_BP: assert property (o_erase_go && o_erase_kind == 2'h2 |->
      o_status[`SFP_ST_BP_HI:`SFP_ST_BP_LO] == 3'h0) else $error("chip erase while protected");
   AST_PROT: assert property (o_erase_go && o_erase_kind != 2'h2 |->
      !prot(o_status[`SFP_ST_BP_HI:`SFP_ST_BP_LO], o_addr)) else $error("erase in protected area");
   AST_WEL_GO: assert property (o_erase_go |-> o_status[1] || $past(o_status[1]))
      else $error("erase without write enable");
   AST_WEL_DROP: assert property (o_erase_go |-> ##[0:3] !o_status[`SFP_ST_WEL])
      else $error("write enable kept after erase");
   AST_GO_FRAME: assert property (o_erase_go |-> i_cs_n ##1 !o_erase_go)
      else $error("erase start not a single pulse after deselect");
   AST_REF_PULSE: assert property (o_refused |-> !o_erase_go ##1 !o_refused)
      else $error("refusal not a single pulse");
   AST_LOCKED: assert property (wp_lo == 4'hf && o_status[7] |=> $stable(o_status[7:2]))
      else $error("locked status changed");
   AST_HOLD_OE: assert property (hold_lo >= 4'h8 |-> !o_so_oe && !o_io1_oe)
      else $error("output driven while paused");
endmodule : sfp_cmd_props

// file: sim/sfp_host.sv
module sfp_host (
   // serial pins toward the device
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si,
   output logic o_hold_n,
   // serial pins from the device
   input wire logic i_so,
   input wire logic i_so_oe,
   input wire logic i_io1,
   input wire logic i_io1_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] rd_got;
   logic rd_ok;
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_si = 1'b0;
      o_hold_n = 1'b1;
   end
   // data set while the clock is low, taken by the device on the rise
   task automatic put_bit(input logic b);
      o_si = b;
      #24 o_sck = 1'b1;
      #24 o_sck = 1'b0;
   endtask : put_bit
   // pause with the clock low, wiggle clock and data, resume still selected
   task automatic pause();
      o_hold_n = 1'b0;
      repeat (8) #24 {o_sck, o_si} = {~o_sck, ~o_si};
      #24 o_hold_n = 1'b1;
      #24;
   endtask : pause
   // whole bytes msb first; cut stops the last byte after that many bits;
   // rd_n further clocks sample the device, two lines at a time in dual
   task automatic frame(input logic [7:0] q[$], input int cut, input int pause_at,
      input int rd_n, input logic dual);
      o_cs_n = 1'b0;
      rd_ok = 1'b1;
      #24;
      foreach (q[i]) begin
         for (int k = 7; k >= 0; k--) begin
            if (8 * i + 7 - k == pause_at) pause();
            if (!(cut > 0 && i == q.size() - 1 && 7 - k >= cut)) put_bit(q[i][k]);
         end
      end
      for (int j = 0; j < rd_n; j++) begin
         if (8 * q.size() + j == pause_at) pause();
         #24 o_sck = 1'b1;
         rd_got = dual ? {rd_got[13:0], i_so, i_io1} : {rd_got[14:0], i_so};
         rd_ok = rd_ok & i_so_oe & (i_io1_oe == dual);
         #24 o_sck = 1'b0;
      end
      #24 o_cs_n = 1'b1;
      o_si = ~o_si;
      #96;
   endtask : frame
endmodule : sfp_host

// file: sim/sfp_cmd_bench.sv
`include "sfp_map.svh"
module sfp_cmd_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_clk, i_rst, i_cs_n, i_sck, i_si, i_hold_n, i_wp_n, i_busy;
   logic [7:0] i_rd_data;
   logic o_so, o_so_oe, o_io1, o_io1_oe, o_rd_req, o_erase_go, o_prog_go, o_refused;
   logic [1:0] o_erase_kind;
   logic [7:0] o_prog_data, o_status;
   logic [23:0] o_addr, ra;
   logic [27:0] notes[$];
   logic [27:0] exp;
   int fail_count = 0;
   int tests_run = 0;
   int seed = 49748;
   int rd_count = 0;
   logic [7:0] rd_key;
   sfp_cmd DUT (.*);
   sfp_host u_host (.o_cs_n(i_cs_n), .o_sck(i_sck), .o_si(i_si), .o_hold_n(i_hold_n),
      .i_so(o_so), .i_so_oe(o_so_oe), .i_io1(o_io1), .i_io1_oe(o_io1_oe));
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   initial begin
      i_rd_data = 8'h00;
      rd_key = 8'($random(seed));
      // array byte follows the address: low address bits scrambled by a random key
      forever @(posedge i_clk) #1 i_rd_data = o_addr[7:0] ^ rd_key;
   end
   task automatic check(input string what, input logic [27:0] e, input logic [27:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask : check
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up
   // each erase start, program start or refusal is matched with the oldest note
   always @(posedge i_clk) begin
      if (o_rd_req === 1'b1) rd_count++;
      if (o_erase_go === 1'b1 || o_refused === 1'b1 || o_prog_go === 1'b1) begin
         exp = notes.size() > 0 ? notes.pop_front() : 28'hfffffff;
         check("result", exp, o_prog_go ? {4'h3, o_addr[15:0], o_prog_data} :
            {o_erase_go, o_refused, o_erase_go ? o_erase_kind : 2'h0,
            (o_erase_go && o_erase_kind != 2'h2) ? o_addr : 24'h0});
      end
   end
   task automatic send(input logic [7:0] q[$], input int cut = 0, input int pause_at = -1,
      input int rd_n = 0, input logic dual = 1'b0);
      @(posedge i_clk);
      #1;
      u_host.frame(q, cut, pause_at, rd_n, dual);
      repeat (4) @(posedge i_clk);
   endtask : send
   task automatic write_enable_cmd();
      send('{`SFP_OP_WRITE_ENABLE_CMD});
   endtask : write_enable_cmd
   task automatic stat(input logic [7:0] e);
      check("status", {20'h0, e}, {20'h0, o_status});
   endtask : stat
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      i_rst = 1'b1;
      i_wp_n = 1'b1;
      i_busy = 1'b0;
      repeat (8) @(posedge i_clk);
      #1 i_rst = 1'b0;
      repeat (4) @(posedge i_clk);
      stat(8'h1c);
      notes.push_back(28'h4000000);
      send('{`SFP_OP_SECT, 8'h00, 8'h00, 8'h00});
      write_enable_cmd();
      send('{`SFP_OP_WRSTAT, 8'h00});
      stat(8'h00);
      ra = {2'h0, 10'($random(seed)), 12'h000};
      write_enable_cmd();
      notes.push_back({4'h8, ra});
      send('{`SFP_OP_SECT, ra[23:16], ra[15:8], ra[7:0]}, 0, 13);
      write_enable_cmd();
      notes.push_back(28'h93f0000);
      send('{`SFP_OP_BLOCK, 8'h3f, 8'h00, 8'h00});
      write_enable_cmd();
      send('{`SFP_OP_WRSTAT, 8'h84});
      stat(8'h84);
      send('{`SFP_OP_RDSTAT}, 0, 11, 8);
      check("status read", 28'h84, {20'h0, u_host.rd_got[7:0]});
      check("read enables", 28'h1, {27'h0, u_host.rd_ok});
      write_enable_cmd();
      notes.push_back(28'h4000000);
      send('{`SFP_OP_SECT, 8'h3f, 8'h10, 8'h00});
      write_enable_cmd();
      notes.push_back(28'h83ef000);
      send('{`SFP_OP_SECT, 8'h3e, 8'hf0, 8'h00});
      write_enable_cmd();
      notes.push_back(28'h4000000);
      send('{`SFP_OP_CHIP1});
      @(posedge i_clk) #1 i_wp_n = 1'b0;
      write_enable_cmd();
      notes.push_back(28'h4000000);
      send('{`SFP_OP_WRSTAT, 8'h00});
      stat(8'h84);
      @(posedge i_clk) #1 i_wp_n = 1'b1;
      write_enable_cmd();
      send('{`SFP_OP_WRSTAT, 8'h00});
      write_enable_cmd();
      send('{`SFP_OP_SECT, 8'h00, 8'h00, 8'h00}, 5);
      stat(8'h02);
      notes.push_back(28'ha000000);
      send('{`SFP_OP_CHIP2});
      stat(8'h00);
      write_enable_cmd();
      notes.push_back({4'h3, 16'h31fe, 8'h5a});
      notes.push_back({4'h3, 16'h31ff, 8'hc3});
      send('{`SFP_OP_PROG, 8'h0a, 8'h31, 8'hfe, 8'h5a, 8'hc3});
      stat(8'h00);
      @(posedge i_clk) #1 i_busy = 1'b1;
      write_enable_cmd();
      notes.push_back(28'h4000000);
      send('{`SFP_OP_SECT, 8'h00, 8'h10, 8'h00});
      stat(8'h01);
      @(posedge i_clk) #1 i_busy = 1'b0;
      rd_count = 0;
      send('{`SFP_OP_DREAD, ra[23:16], ra[15:8], 8'h7f, 8'h00}, 0, -1, 8, 1'b1);
      check("dual read", {12'h0, 8'h7f ^ rd_key, 8'h80 ^ rd_key}, {12'h0, u_host.rd_got});
      check("dual enables", 28'h1, {27'h0, u_host.rd_ok});
      check("read requests", 28'h3, 28'(rd_count));
      repeat (20) @(posedge i_clk);
      wrap_up();
   end
   initial begin
      #150us;
      fail_count++;
      wrap_up();
   end
endmodule : sfp_cmd_bench
bind sfp_cmd sfp_cmd_props u_props (.*);
